// [rtl/abd_pkg.sv]
// auto-baud measurement package: register map, fields, clock ratios
// assumes an AHB-Lite slave with 32-bit data, one word per register
// Contract
// - setting the arm bit starts calibration; receiver held idle meanwhile
// - during calibration the receive line gates the divisor counter
// - counting starts at first rising edge after the start bit
// - fifth rising edge ends it: keep count, clear arm, set receive flag
// - receive flag stays set until software reads receive data
// - divisor high and low form one 16-bit counter while calibrating
// - counter ticks at one eighth of the generator base clock
// - select bits 00:/512, 01,10:/128, 11:/32 of the oscillator
// - counter starts at one, result exceeds true count by one
// - wake-on-break with arm skips break, measures following byte
// - low byte carries into high byte so overflow shows in high byte
package autobaud_pkg;
  localparam logic [7:0] baud_control_off = 8'h00;
  localparam logic [7:0] baud_divisor_low_off = 8'h04;
  localparam logic [7:0] baud_divisor_high_off = 8'h08;
  localparam logic [7:0] receive_data_off = 8'h0C;
  localparam logic [7:0] status_off = 8'h10;
  localparam int arm_bit_pos = 0;
  localparam int wake_bit_pos = 1;
  localparam int wide_bit_pos = 3;
  localparam int hs_bit_pos = 4;
  localparam int busy_bit_pos = 0;
  localparam int flag_bit_pos = 1;
  localparam logic [15:0] count_start = 16'h0001;
  localparam logic [2:0] rising_edges = 3'h5;
  localparam logic [8:0] div_512 = 9'h1FF;
  localparam logic [8:0] div_128 = 9'h07F;
  localparam logic [8:0] div_32 = 9'h01F;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  typedef struct packed {
    logic arm;
    logic wake;
    logic wide;
    logic hs;
  } ctrl_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait_start = 2'b01,
    st_count = 2'b11,
    st_skip_break = 2'b10
  } autobaud_state_t;
endpackage : autobaud_pkg

// [rtl/abd_sync.sv]
// two-flop synchroniser for the receive pin
// assumes the pin is asynchronous to hclk
`timescale 1ns/10ps
module autobaud_sync (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin and synchronised level
  input wire logic d,
  output logic q
);
  logic meta_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : autobaud_sync

// [rtl/abd_tick.sv]
// divider making the auto-baud counter tick enable
// assumes select bits are stable during a measurement
`timescale 1ns/10ps
module autobaud_tick
  import autobaud_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic run,
  input wire logic wide,
  input wire logic hs,
  // one-cycle enable
  output logic tick
);
  logic [8:0] cnt_r;
  logic [8:0] top;
  always_comb begin
    case ({wide, hs})
      2'b00: top = div_512;
      2'b11: top = div_32;
      default: top = div_128;
    endcase
  end
  // restarting with run keeps the phase aligned to the first edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 9'h000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= 9'h000;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r == top);
      cnt_r <= (cnt_r == top) ? 9'h000 : cnt_r + 9'h001;
    end
  end
endmodule : autobaud_tick

// [rtl/uart_autobaud_detect.sv]
// auto-baud measurement block with AHB-Lite register slave
// assumes single word transfers; receive pin asynchronous to hclk
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module uart_autobaud_detect
  import autobaud_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial line and receiver control
  input wire logic rx_pin,
  output logic rx_hold_idle,
  output logic receive_flag
);
  ctrl_t ctrl_r;
  autobaud_state_t state_r;
  logic [15:0] baud_divisor_pair_r;
  logic [7:0] receive_data_reg_r;
  logic rx_s;
  logic rx_d_r;
  logic rise;
  logic tick;
  logic start_cnt;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [9:0] tick_period;
  logic [9:0] gap_r;
  logic [2:0] edges_r;
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic take;
  logic done;
  logic run;

  autobaud_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(rx_pin),
    .q(rx_s)
  );

  assign run = (state_r == st_count);

  autobaud_tick u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .wide(ctrl_r.wide),
    .hs(ctrl_r.hs),
    .tick(tick)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_d_r <= 1'b1;
    end else begin
      rx_d_r <= rx_s;
    end
  end
  assign rise = rx_s && !rx_d_r;
  // in wait_start the line idles high, so any rise closes the start bit
  assign start_cnt = state_r == st_wait_start && ctrl_r.arm && rise;
  assign done = run && rise && (edges_r == rising_edges - 3'h1);

  // address phase capture
  assign take = hsel && hready && htrans == htrans_nonseq;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite;
      if (take) begin
        addr_r <= haddr;
      end
    end
  end

  // measurement sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= st_idle;
      edges_r <= 3'h0;
    end else begin
      case (state_r)
        st_idle: begin
          edges_r <= 3'h0;
          if (ctrl_r.arm) begin
            state_r <= ctrl_r.wake ? st_skip_break : st_wait_start;
          end
        end
        // break is a long low; its closing rise ends the skip
        st_skip_break: begin
          if (!ctrl_r.arm) begin
            state_r <= st_idle;
          end else if (rise) begin
            state_r <= st_wait_start;
          end
        end
        st_wait_start: begin
          if (!ctrl_r.arm) begin
            state_r <= st_idle;
          end else if (start_cnt) begin
            state_r <= st_count;
            edges_r <= 3'h1;
          end
        end
        st_count: begin
          if (!ctrl_r.arm) begin
            state_r <= st_idle;
          end else if (rise) begin
            edges_r <= edges_r + 3'h1;
            if (done) begin
              state_r <= st_idle;
            end
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // control register; hardware clear of arm wins over a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= '0;
    end else begin
      if (wr_pend_r && addr_r == baud_control_off) begin
        ctrl_r.arm <= hwdata[arm_bit_pos];
        ctrl_r.wake <= hwdata[wake_bit_pos];
        ctrl_r.wide <= hwdata[wide_bit_pos];
        ctrl_r.hs <= hwdata[hs_bit_pos];
      end
      if (done) begin
        ctrl_r.arm <= 1'b0;
      end
    end
  end

  // divisor pair: software value or the running measurement
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_divisor_pair_r <= 16'h0000;
    end else if (start_cnt) begin
      baud_divisor_pair_r <= count_start;
    end else if (run && tick && !done) begin
      baud_divisor_pair_r <= baud_divisor_pair_r + 16'h0001;
    end else if (!run && wr_pend_r && addr_r == baud_divisor_low_off) begin
      baud_divisor_pair_r[7:0] <= hwdata[7:0];
    end else if (!run && wr_pend_r && addr_r == baud_divisor_high_off) begin
      baud_divisor_pair_r[15:8] <= hwdata[7:0];
    end
  end

  // receive flag: set wins over the clearing read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receive_flag <= 1'b0;
      receive_data_reg_r <= 8'h00;
    end else if (done) begin
      receive_flag <= 1'b1;
      receive_data_reg_r <= 8'h00;
    end else if (take && !hwrite && haddr == receive_data_off) begin
      receive_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_hold_idle <= 1'b0;
    end else begin
      rx_hold_idle <= ctrl_r.arm && !done;
    end
  end

  // read views built from the field positions
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[arm_bit_pos] = ctrl_r.arm;
    ctrl_word[wake_bit_pos] = ctrl_r.wake;
    ctrl_word[wide_bit_pos] = ctrl_r.wide;
    ctrl_word[hs_bit_pos] = ctrl_r.hs;
    status_word = 32'h0000_0000;
    status_word[busy_bit_pos] = run;
    status_word[flag_bit_pos] = receive_flag;
  end

  // read data registered in the address phase, zero-wait answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr)
        baud_control_off: hrdata <= ctrl_word;
        baud_divisor_low_off: hrdata <= {24'h0, baud_divisor_pair_r[7:0]};
        baud_divisor_high_off: hrdata <= {24'h0, baud_divisor_pair_r[15:8]};
        receive_data_off: hrdata <= {24'h0, receive_data_reg_r};
        status_off: hrdata <= status_word;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // expected tick spacing per select setting, for the divider check
  always_comb begin
    case ({ctrl_r.wide, ctrl_r.hs})
      2'b00: tick_period = 10'(div_512) + 10'h001;
      2'b11: tick_period = 10'(div_32) + 10'h001;
      default: tick_period = 10'(div_128) + 10'h001;
    endcase
  end

  // cycles since the last tick; zero while no reference tick is known
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r <= 10'h000;
    end else if (!run || (wr_pend_r && addr_r == baud_control_off)) begin
      gap_r <= 10'h000;
    end else if (tick) begin
      gap_r <= 10'h001;
    end else if (gap_r != 10'h000) begin
      gap_r <= gap_r + 10'h001;
    end
  end

  property p_arm_clears;
    @(posedge hclk) disable iff (!hresetn) done |=> !ctrl_r.arm && receive_flag;
  endproperty
  a_arm_clears: assert property (p_arm_clears) else $error("arm not cleared");
  property p_hold;
    @(posedge hclk) disable iff (!hresetn) run |=> rx_hold_idle || !ctrl_r.arm;
  endproperty
  a_hold: assert property (p_hold) else $error("receiver not held");
  property p_start;
    @(posedge hclk) disable iff (!hresetn)
      start_cnt |=> run && edges_r == 3'h1 && baud_divisor_pair_r == count_start;
  endproperty
  a_start: assert property (p_start) else $error("count did not start at edge");
  property p_first;
    @(posedge hclk) disable iff (!hresetn)
      $rose(run) |-> baud_divisor_pair_r == count_start;
  endproperty
  a_first: assert property (p_first) else $error("count not at one");
  property p_step;
    @(posedge hclk) disable iff (!hresetn)
      $past(run) && run && !$past(tick) |-> $stable(baud_divisor_pair_r);
  endproperty
  a_step: assert property (p_step) else $error("count moved without tick");
  property p_inc;
    @(posedge hclk) disable iff (!hresetn)
      run && tick && !done |=> baud_divisor_pair_r == $past(baud_divisor_pair_r) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("16-bit count wrong");
  property p_carry;
    @(posedge hclk) disable iff (!hresetn)
      run && tick && !done && baud_divisor_pair_r[7:0] == 8'hFF
      |=> baud_divisor_pair_r[15:8] == $past(baud_divisor_pair_r[15:8]) + 8'h01;
  endproperty
  a_carry: assert property (p_carry) else $error("no carry into high byte");
  property p_flag_hold;
    @(posedge hclk) disable iff (!hresetn)
      receive_flag && !(take && !hwrite && haddr == receive_data_off) |=> receive_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_skip;
    @(posedge hclk) disable iff (!hresetn)
      state_r == st_idle && ctrl_r.arm && ctrl_r.wake |=> state_r == st_skip_break;
  endproperty
  a_skip: assert property (p_skip) else $error("break not skipped");
  property p_tick_gap;
    @(posedge hclk) disable iff (!hresetn) tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too fast");
  property p_gate;
    @(posedge hclk) disable iff (!hresetn)
      state_r == st_wait_start && !wr_pend_r |=> $stable(baud_divisor_pair_r) || run;
  endproperty
  a_gate: assert property (p_gate) else $error("count before edge");
  property p_flag_src;
    @(posedge hclk) disable iff (!hresetn) $rose(receive_flag) |-> $past(done);
  endproperty
  a_flag_src: assert property (p_flag_src) else $error("flag set without measurement");
  property p_hold_release;
    @(posedge hclk) disable iff (!hresetn) done |=> !rx_hold_idle;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("receiver still held");
  property p_abort;
    @(posedge hclk) disable iff (!hresetn)
      state_r != st_idle && !ctrl_r.arm |=> state_r == st_idle;
  endproperty
  a_abort: assert property (p_abort) else $error("sequence ran without arm");
  property p_period;
    @(posedge hclk) disable iff (!hresetn)
      run && tick && gap_r != 10'h000 |-> gap_r == tick_period;
  endproperty
  a_period: assert property (p_period) else $error("tick spacing wrong");
  property p_tick_off;
    @(posedge hclk) disable iff (!hresetn) !run |=> !tick;
  endproperty
  a_tick_off: assert property (p_tick_off) else $error("tick while idle");
  property p_skip_exit;
    @(posedge hclk) disable iff (!hresetn)
      state_r == st_skip_break && ctrl_r.arm && rise |=> state_r == st_wait_start;
  endproperty
  a_skip_exit: assert property (p_skip_exit) else $error("break end missed");
  property p_clear;
    @(posedge hclk) disable iff (!hresetn)
      receive_flag && !done && take && !hwrite && haddr == receive_data_off
      |=> !receive_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared by read");
  property p_locked;
    @(posedge hclk) disable iff (!hresetn)
      run && wr_pend_r && !tick |=> $stable(baud_divisor_pair_r);
  endproperty
  a_locked: assert property (p_locked) else $error("divisor written while counting");
  c_done: cover property (@(posedge hclk) done);
  c_skip: cover property (@(posedge hclk) state_r == st_skip_break ##1 state_r == st_wait_start);
  c_clear: cover property (@(posedge hclk) $fell(receive_flag));
  c_carry: cover property (@(posedge hclk) done && baud_divisor_pair_r[15:8] != 8'h00);
  c_abort: cover property (@(posedge hclk)
    state_r == st_wait_start ##1 state_r == st_idle && !receive_flag);
endmodule : uart_autobaud_detect

// [bench/abd_node.sv]
// remote serial node: sends frames and breaks on the receive line
// assumes the caller enters its tasks just after a rising hclk edge
`timescale 1ns/10ps
module autobaud_node (
  // clock
  input wire logic hclk,
  // serial line, idle high
  output logic rx
);
  initial rx = 1'b1;

  task automatic hold(input logic v, input int cyc);
    rx <= v;
    repeat (cyc) @(posedge hclk);
  endtask : hold

  // start, eight bits lsb first, stop
  task automatic send(input logic [7:0] b, input int bp);
    @(posedge hclk);
    hold(1'b0, bp);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], bp);
    end
    hold(1'b1, bp);
  endtask : send

  // long low, then one idle bit before the next frame
  task automatic send_break(input int bp);
    @(posedge hclk);
    hold(1'b0, 13 * bp);
    hold(1'b1, bp);
  endtask : send_break
endmodule : autobaud_node

// [bench/testbench.sv]
// self-checking bench for the auto-baud block over AHB-Lite
// assumes zero-wait slave; node model drives the receive pin
`timescale 1ns/10ps
module testbench;
  import autobaud_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic rx_pin, rx_hold_idle, receive_flag;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h0000_1153;

  assign hready = hreadyout;

  uart_autobaud_detect DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_pin(rx_pin),
    .rx_hold_idle(rx_hold_idle), .receive_flag(receive_flag));
  autobaud_node node (.hclk(hclk), .rx(rx_pin));

  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // count expected over eight bit periods, count value one before the first tick
  function automatic int exp_count(input int bp, input logic wide, input logic hs);
    int t;
    t = (wide && hs) ? 512 / 16 : ((wide || hs) ? 128 : 512);
    return 1 + 8 * bp / t;
  endfunction : exp_count

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= htrans_nonseq;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : ahb

  task automatic measure(input logic wide, input logic hs, input logic wake, input int bp);
    logic [31:0] r;
    logic [31:0] lo;
    int e;
    int d;
    int n;
    e = exp_count(bp, wide, hs);
    ahb(1'b1, baud_control_off, {27'h0, hs, wide, 1'b0, wake, 1'b1}, r);
    // hold output follows the arm bit one edge later
    repeat (2) @(posedge hclk);
    check({31'h0, rx_hold_idle}, 32'h1);
    if (wake) node.send_break(bp);
    node.send(8'h55, bp);
    n = 0;
    while (receive_flag !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    check({31'h0, receive_flag}, 32'h1);
    check({31'h0, rx_hold_idle}, 32'h0);
    ahb(1'b0, baud_control_off, 32'h0, r);
    check(r & 32'h1, 32'h0);
    ahb(1'b0, baud_divisor_low_off, 32'h0, lo);
    ahb(1'b0, baud_divisor_high_off, 32'h0, r);
    // tick phase is fixed by the first edge, but edge latency can shift one count, so allow one either way
    d = int'({r[7:0], lo[7:0]}) - e;
    check((d >= -1 && d <= 1) ? 32'(e) : {16'h0, r[7:0], lo[7:0]}, 32'(e));
    ahb(1'b0, status_off, 32'h0, r);
    check(r & 32'h2, 32'h2);
    ahb(1'b0, receive_data_off, 32'h0, r);
    check(r, 32'h0);
    @(posedge hclk);
    check({31'h0, receive_flag}, 32'h0);
  endtask : measure

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    repeat (80000) @(posedge hclk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    logic [7:0] idle_addr [3];
    idle_addr = '{baud_control_off, status_off, 8'h20};
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (idle_addr[i]) begin
      ahb(1'b0, idle_addr[i], 32'h0, r);
      check(r, 32'h0);
    end
    // arm, then abort before any frame arrives
    ahb(1'b1, baud_control_off, 32'h1, r);
    repeat (2) @(posedge hclk);
    check({31'h0, rx_hold_idle}, 32'h1);
    ahb(1'b1, baud_control_off, 32'h0, r);
    repeat (2) @(posedge hclk);
    check({31'h0, rx_hold_idle}, 32'h0);
    ahb(1'b0, status_off, 32'h0, r);
    check(r, 32'h0);
    for (int m = 0; m < 4; m++) begin
      measure(m[1], m[0], 1'b0, 200 + int'(xs() % 32'd400));
    end
    measure(1'b0, 1'b0, 1'b1, 300);
    measure(1'b1, 1'b1, 1'b0, 1100);
    report_and_stop();
  end
endmodule : testbench
